// *** bench/emas_mem_model.sv ***
// Behavioural external memory with programmable ready wait states
`timescale 1ns/10ps
module emas_mem_model (
	// Clock and wait count
	input  wire logic                 i_core_clk,
	input  wire logic [7:0]           i_wait,
	// Memory pins
	input  wire logic                 i_zone_select_n,
	input  wire logic                 i_rw_direction,
	input  wire emas_pkg::emas_addr_t i_ext_address,
	input  wire emas_pkg::emas_data_t i_ext_data,
	input  wire logic                 i_ext_data_oe,
	output emas_pkg::emas_data_t      o_ext_data,
	output logic                      o_external_ready
);
	import emas_pkg::*;
	emas_data_t mem [0:15];
	emas_data_t last_q = 16'h0000;
	logic [7:0] wcnt_q = 8'h00;
	logic       zone_q = 1'b1;
	logic       dir_q  = 1'b1;
	// Read data only while selected for a read, else a changing pattern
	assign o_ext_data = (!i_zone_select_n && i_rw_direction) ? mem[i_ext_address[3:0]] : ~last_q;
	always @(posedge i_core_clk) begin
		last_q <= o_ext_data;
		zone_q <= i_zone_select_n;
		dir_q <= i_rw_direction;
		// Capture at deselect proves data held through trail
		if (i_zone_select_n && !zone_q && !dir_q && i_ext_data_oe) mem[i_ext_address[3:0]] <= i_ext_data;
		if (!i_zone_select_n && zone_q) wcnt_q <= i_wait;
		else if (wcnt_q != 8'h00) wcnt_q <= wcnt_q - 8'h01;
		// Low for the wait count, then high until after deselect
		o_external_ready <= !(!i_zone_select_n && (zone_q ? i_wait != 8'h00 : wcnt_q > 8'h01));
	end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the access sequencer
`timescale 1ns/10ps
`include "emas_map.svh"
module tb_top;
	import emas_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        bclk, zone_n, rd_n, wr_n, dir, oe, rdy;
	emas_addr_t  xaddr;
	emas_data_t  xdo, xdi;
	logic [7:0]  wait_n = 8'h00;
	logic [7:0]  scnt;
	int          error_cnt = 0;
	int          num_checks = 0;
	logic [31:0] r;
	always #25 clk = ~clk;
	emas_sequencer i_dut (.i_core_clk(clk), .i_rst(rst), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .o_bus_clock_out(bclk), .o_zone_select_n(zone_n),
		.o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n), .o_rw_direction(dir), .o_ext_address(xaddr),
		.i_ext_data(xdi), .o_ext_data(xdo), .o_ext_data_oe(oe), .i_external_ready(rdy));
	emas_mem_model i_mem (.i_core_clk(clk), .i_wait(wait_n), .i_zone_select_n(zone_n), .i_rw_direction(dir),
		.i_ext_address(xaddr), .i_ext_data(xdo), .i_ext_data_oe(oe), .o_ext_data(xdi), .o_external_ready(rdy));
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task finish_test;
		$display("Checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task access(input logic [31:0] cfg, input logic w, input logic [18:0] a, input logic [15:0] d);
		ahb(1'b1, `EMAS_OFF_CFG, cfg);
		ahb(1'b1, `EMAS_OFF_ADDR, {13'h0, a});
		ahb(1'b1, `EMAS_OFF_WDATA, {16'h0, d});
		ahb(1'b1, `EMAS_OFF_CMD, {30'h0, w, 1'b1});
		for (int i = 0; i < 200; i++) begin
			ahb(1'b0, `EMAS_OFF_STAT, 32'h0);
			if (r[0] === 1'b0 && i > 2) break;
		end
	endtask
	// Strobe-low cycles of the current access; pin relations flagged each cycle
	always @(posedge clk) begin
		if ($fell(zone_n)) scnt <= 8'h00;
		else if (!rd_n || !wr_n) scnt <= scnt + 8'h01;
		if (!rst && $fell(zone_n)) check("bclk at start", {31'h0, bclk}, 32'h1);
		if (!rst && !wr_n) check("oe at strobe", {31'h0, oe}, 32'h1);
		if (!rst && zone_n && $stable(zone_n)) check("dir idle", {31'h0, dir}, 32'h1);
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		ahb(1'b0, `EMAS_OFF_CFG, 32'h0);
		check("cfg reset", r, {13'h0, `EMAS_CFG_RST});
		ahb(1'b0, 8'h20, 32'h0);
		check("unmapped", r, 32'h0);
		check("hresp okay", {31'h0, hresp}, 32'h0);
		$display("Test registers done");
		// Write lead 1 active 2 trail 1
		access(32'h00005119, 1'b1, 19'h00005, 16'ha5c3);
		check("write strobe cycles", {24'h0, scnt}, 32'h2);
		check("addr hold", {13'h0, xaddr}, 32'h5);
		check("zone end", {31'h0, zone_n}, 32'h1);
		check("dir end", {31'h0, dir}, 32'h1);
		$display("Test write done");
		// Read lead 1 active 3 trail 1 with ready ignored
		wait_n <= 8'h06;
		access(32'h00000059, 1'b0, 19'h00005, 16'h0);
		check("read no ready", {16'h0, r[31:16]}, 32'ha5c3);
		check("strobe no ready", {24'h0, scnt}, 32'h3);
		$display("Test ready off done");
		access(32'h00010059, 1'b0, 19'h00005, 16'h0);
		check("read sync", {16'h0, r[31:16]}, 32'ha5c3);
		check("sync waited", {31'h0, scnt > 8'h03}, 32'h1);
		$display("Test sync ready done");
		// Async read lead 1 active 5 trail 1: first sample lies two ticks earlier
		access(32'h00030069, 1'b0, 19'h00005, 16'h0);
		check("read async", {16'h0, r[31:16]}, 32'ha5c3);
		check("async waited", {31'h0, scnt > 8'h05}, 32'h1);
		$display("Test async ready done");
		// Doubled timing: write lead 1 active 2 trail 1, read lead 1 active 3 trail 1
		access(32'h00045159, 1'b1, 19'h00006, 16'h3c5a);
		check("doubled write strobe", {24'h0, scnt}, 32'h4);
		access(32'h00045159, 1'b0, 19'h00006, 16'h0);
		check("doubled read", {16'h0, r[31:16]}, 32'h3c5a);
		check("doubled read strobe", {24'h0, scnt}, 32'h6);
		$display("Test doubled timing done");
		finish_test();
	end
	initial begin
		#400000;
		error_cnt++;
		finish_test();
	end
endmodule

// *** logic/emas_map.svh ***
// Register offsets, field positions, reset values and widths of the access sequencer
`ifndef EMAS_MAP_SVH
`define EMAS_MAP_SVH

`define EMAS_AW          19
`define EMAS_DW          16
`define EMAS_CFG_W       19

`define EMAS_OFF_CFG     8'h00
`define EMAS_OFF_ADDR    8'h04
`define EMAS_OFF_WDATA   8'h08
`define EMAS_OFF_CMD     8'h0c
`define EMAS_OFF_STAT    8'h10

`define EMAS_F_RD_LEAD   2:0
`define EMAS_F_RD_ACT    5:3
`define EMAS_F_RD_TRAIL  7:6
`define EMAS_F_WR_LEAD   10:8
`define EMAS_F_WR_ACT    13:11
`define EMAS_F_WR_TRAIL  15:14
`define EMAS_B_USE_RDY   16
`define EMAS_B_RDY_MODE  17
`define EMAS_B_DOUBLED   18

`define EMAS_B_CMD_GO    0
`define EMAS_B_CMD_WR    1

`define EMAS_CFG_RST     19'h0ffff
`define EMAS_PH_MAX      5'h1f
`define EMAS_PH_ONE      5'h01
`define EMAS_PH_ZERO     5'h00

`endif

// *** logic/emas_pkg.sv ***
// Types shared by the access sequencer
`include "emas_map.svh"
package emas_pkg;
	typedef logic [`EMAS_AW-1:0] emas_addr_t;
	typedef logic [`EMAS_DW-1:0] emas_data_t;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_ALIGN = 5'h02,
		ST_LEAD  = 5'h04,
		ST_ACT   = 5'h08,
		ST_TRAIL = 5'h10
	} emas_state_t;
endpackage

// *** logic/emas_sequencer.sv ***
// External memory access sequencer with AHB-Lite register slave
`timescale 1ns/10ps
`include "emas_map.svh"

// Functional notes
// - Accesses start on rising bus clock edge
// - Alignment cycle keeps every strobe inactive
// - Ready ignored when ready use disabled
// - Address holds last value when inactive
// - Write data driven from strobe low
// - Write data held through write trail
// - Direction low for writes, high at end
// - Zone select low at start, high at end
// - Synchronous ready sampled after lead plus active
// - Asynchronous ready sampled two timing clock cycles earlier
// - Phases counted in timing clock cycles
// - Even counts rising edge, odd falling
module emas_sequencer (
	// Clock and reset
	input  wire logic               i_core_clk,
	input  wire logic               i_rst,
	// AHB-Lite slave
	input  wire logic               i_hsel,
	input  wire logic [31:0]        i_haddr,
	input  wire logic [1:0]         i_htrans,
	input  wire logic               i_hwrite,
	input  wire logic [2:0]         i_hsize,
	input  wire logic [31:0]        i_hwdata,
	input  wire logic               i_hready,
	output logic      [31:0]        o_hrdata,
	output logic                    o_hreadyout,
	output logic                    o_hresp,
	// External memory interface
	output logic                    o_bus_clock_out,
	output logic                    o_zone_select_n,
	output logic                    o_read_strobe_n,
	output logic                    o_write_strobe_n,
	output logic                    o_rw_direction,
	output emas_pkg::emas_addr_t    o_ext_address,
	input  wire emas_pkg::emas_data_t i_ext_data,
	output emas_pkg::emas_data_t    o_ext_data,
	output logic                    o_ext_data_oe,
	input  wire logic               i_external_ready
);
	import emas_pkg::*;

	// Register file
	logic [`EMAS_CFG_W-1:0] cfg_q, cfg_d;
	emas_addr_t             addr_q, addr_d;
	emas_data_t             wdata_q, wdata_d;
	emas_data_t             rdata_q, rdata_d;
	logic                   pend_q, pend_d;
	logic                   pend_wr_q, pend_wr_d;
	logic                   ap_wr_q, ap_wr_d;
	logic [7:0]             ap_addr_q, ap_addr_d;
	logic [31:0]            hrdata_q, hrdata_d;
	logic                   ap_valid;
	logic                   busy;

	// Sequencer
	emas_state_t            st_q, st_d;
	logic [4:0]             ph_q, ph_d;
	logic [4:0]             ph_inc;
	logic                   cur_wr_q, cur_wr_d;
	logic [1:0]             rdy_p_q, rdy_p_d;
	logic                   tdiv_q, tdiv_d;
	logic                   bclk_q, bclk_d;
	logic                   tick;
	logic                   take;
	logic                   rdy_ok;
	logic [2:0]             lead, act, trl;

	// Pins
	logic                   zone_n_q, zone_n_d;
	logic                   rd_n_q, rd_n_d;
	logic                   wr_n_q, wr_n_d;
	logic                   dir_q, dir_d;
	emas_addr_t             xaddr_q, xaddr_d;
	emas_data_t             xdata_q, xdata_d;
	logic                   oe_q, oe_d;

	logic                   rdy_s;
	emas_data_t             data_s;

	emas_sync2 #(
		.W(`EMAS_DW + 1)
	) u_sync (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_async    ({i_external_ready, i_ext_data}),
		.o_sync     ({rdy_s, data_s})
	);

	assign busy = pend_q | (st_q != ST_IDLE);

	// Bus slave: read data prepared in address phase, writes applied in data phase
	always_comb begin
		ap_valid  = i_hsel & i_hready & i_htrans[1];
		ap_wr_d   = ap_valid & i_hwrite;
		ap_addr_d = ap_valid ? i_haddr[7:0] : ap_addr_q;
		hrdata_d  = hrdata_q;
		if (ap_valid & ~i_hwrite) begin
			unique case (i_haddr[7:0])
				`EMAS_OFF_CFG:   hrdata_d = {13'h0000, cfg_q};
				`EMAS_OFF_ADDR:  hrdata_d = {13'h0000, addr_q};
				`EMAS_OFF_WDATA: hrdata_d = {16'h0000, wdata_q};
				`EMAS_OFF_STAT:  hrdata_d = {rdata_q, 13'h0000, pend_wr_q, pend_q, busy};
				default:         hrdata_d = 32'h0000_0000;
			endcase
		end
		cfg_d     = cfg_q;
		addr_d    = addr_q;
		wdata_d   = wdata_q;
		pend_d    = take ? 1'b0 : pend_q;
		pend_wr_d = pend_wr_q;
		if (ap_wr_q) begin
			unique case (ap_addr_q)
				`EMAS_OFF_CFG:   cfg_d = i_hwdata[`EMAS_CFG_W-1:0];
				`EMAS_OFF_ADDR:  addr_d = i_hwdata[`EMAS_AW-1:0];
				`EMAS_OFF_WDATA: wdata_d = i_hwdata[`EMAS_DW-1:0];
				`EMAS_OFF_CMD: begin
					if (~busy & i_hwdata[`EMAS_B_CMD_GO]) begin
						pend_d    = 1'b1;
						pend_wr_d = i_hwdata[`EMAS_B_CMD_WR];
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cfg_q     <= `EMAS_CFG_RST;
			addr_q    <= '0;
			wdata_q   <= '0;
			pend_q    <= 1'b0;
			pend_wr_q <= 1'b0;
			ap_wr_q   <= 1'b0;
			ap_addr_q <= 8'h00;
			hrdata_q  <= 32'h0000_0000;
		end else begin
			cfg_q     <= cfg_d;
			addr_q    <= addr_d;
			wdata_q   <= wdata_d;
			pend_q    <= pend_d;
			pend_wr_q <= pend_wr_d;
			ap_wr_q   <= ap_wr_d;
			ap_addr_q <= ap_addr_d;
			hrdata_q  <= hrdata_d;
		end
	end

	// Timing clock tick and derived bus clock at half its rate
	always_comb begin
		tdiv_d = ~tdiv_q & cfg_q[`EMAS_B_DOUBLED];
		tick   = ~cfg_q[`EMAS_B_DOUBLED] | tdiv_q;
		bclk_d = tick ? ~bclk_q : bclk_q;
	end

	// Access phase sequencing
	always_comb begin
		st_d     = st_q;
		ph_d     = ph_q;
		cur_wr_d = cur_wr_q;
		rdy_p_d  = rdy_p_q;
		rdata_d  = rdata_q;
		take     = 1'b0;
		lead     = cur_wr_q ? cfg_q[`EMAS_F_WR_LEAD] : cfg_q[`EMAS_F_RD_LEAD];
		act      = cur_wr_q ? cfg_q[`EMAS_F_WR_ACT] : cfg_q[`EMAS_F_RD_ACT];
		trl      = {1'b0, cur_wr_q ? cfg_q[`EMAS_F_WR_TRAIL] : cfg_q[`EMAS_F_RD_TRAIL]};
		if (act == 3'h0) begin
			act = 3'h1;
		end
		ph_inc   = (ph_q == `EMAS_PH_MAX) ? ph_q : ph_q + `EMAS_PH_ONE;
		// Async mode looks at the sample taken two ticks back
		rdy_ok   = ~cfg_q[`EMAS_B_USE_RDY] | (cfg_q[`EMAS_B_RDY_MODE] ? rdy_p_q[1] : rdy_s);
		if (tick) begin
			rdy_p_d = {rdy_p_q[0], rdy_s};
			unique case (st_q)
				ST_IDLE, ST_ALIGN: begin
					st_d = ST_IDLE;
					if (pend_q) begin
						if (bclk_q) begin
							st_d = ST_ALIGN;
						end else begin
							take     = 1'b1;
							cur_wr_d = pend_wr_q;
							ph_d     = `EMAS_PH_ZERO;
							st_d     = ST_LEAD;
						end
					end
				end
				ST_LEAD: begin
					ph_d = ph_inc;
					if (ph_inc >= {2'b00, lead}) begin
						ph_d = `EMAS_PH_ZERO;
						st_d = ST_ACT;
					end
				end
				ST_ACT: begin
					ph_d = ph_inc;
					if ((ph_inc >= {2'b00, act}) && rdy_ok) begin
						ph_d    = `EMAS_PH_ZERO;
						rdata_d = cur_wr_q ? rdata_q : data_s;
						st_d    = (trl == 3'h0) ? ST_IDLE : ST_TRAIL;
					end
				end
				ST_TRAIL: begin
					ph_d = ph_inc;
					if (ph_inc >= {2'b00, trl}) begin
						st_d = ST_IDLE;
					end
				end
			endcase
		end
	end

	// Pin levels follow the next state so they leave flops
	always_comb begin
		zone_n_d = ~((st_d == ST_LEAD) | (st_d == ST_ACT) | (st_d == ST_TRAIL));
		dir_d    = zone_n_d | ~cur_wr_d;
		rd_n_d   = ~((st_d == ST_ACT) & ~cur_wr_d);
		wr_n_d   = ~((st_d == ST_ACT) & cur_wr_d);
		xaddr_d  = take ? addr_q : xaddr_q;
		xdata_d  = take ? wdata_q : xdata_q;
		// Release the data bus one cycle after direction returns high
		oe_d     = (((st_d == ST_ACT) | (st_d == ST_TRAIL)) & cur_wr_d) | (oe_q & ~dir_q);
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_q     <= ST_IDLE;
			ph_q     <= `EMAS_PH_ZERO;
			cur_wr_q <= 1'b0;
			rdy_p_q  <= 2'b00;
			rdata_q  <= '0;
			tdiv_q   <= 1'b0;
			bclk_q   <= 1'b0;
			zone_n_q <= 1'b1;
			dir_q    <= 1'b1;
			rd_n_q   <= 1'b1;
			wr_n_q   <= 1'b1;
			xaddr_q  <= '0;
			xdata_q  <= '0;
			oe_q     <= 1'b0;
		end else begin
			st_q     <= st_d;
			ph_q     <= ph_d;
			cur_wr_q <= cur_wr_d;
			rdy_p_q  <= rdy_p_d;
			rdata_q  <= rdata_d;
			tdiv_q   <= tdiv_d;
			bclk_q   <= bclk_d;
			zone_n_q <= zone_n_d;
			dir_q    <= dir_d;
			rd_n_q   <= rd_n_d;
			wr_n_q   <= wr_n_d;
			xaddr_q  <= xaddr_d;
			xdata_q  <= xdata_d;
			oe_q     <= oe_d;
		end
	end

	assign o_hrdata         = hrdata_q;
	assign o_hreadyout      = 1'b1;
	assign o_hresp          = 1'b0;
	assign o_bus_clock_out  = bclk_q;
	assign o_zone_select_n  = zone_n_q;
	assign o_read_strobe_n  = rd_n_q;
	assign o_write_strobe_n = wr_n_q;
	assign o_rw_direction   = dir_q;
	assign o_ext_address    = xaddr_q;
	assign o_ext_data       = xdata_q;
	assign o_ext_data_oe    = oe_q;

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	zone_start_rise_a: assert property ($fell(zone_n_q) |-> $rose(bclk_q))
		else $error("zone select fell off a rising bus clock edge");
	align_inactive_a: assert property (st_q == ST_ALIGN |-> zone_n_q && rd_n_q && wr_n_q && dir_q)
		else $error("pin active during alignment");
	ready_ignored_a: assert property (tick && st_q == ST_ACT && !cfg_q[`EMAS_B_USE_RDY] && ph_inc >= {2'b00, act}
		|=> st_q != ST_ACT)
		else $error("access stalled with ready use disabled");
	addr_hold_a: assert property (!$stable(xaddr_q) |-> st_q == ST_LEAD && $past(st_q) != ST_LEAD)
		else $error("address changed outside access start");
	data_drive_a: assert property ($rose(oe_q) |-> $fell(wr_n_q))
		else $error("data driven without write strobe falling");
	data_release_a: assert property ($rose(dir_q) && oe_q |=> !oe_q)
		else $error("data bus not released after direction high");
	trail_data_a: assert property (st_q == ST_TRAIL && cur_wr_q |-> oe_q && $stable(xdata_q))
		else $error("write data not held in trail");
	dir_start_a: assert property ($fell(dir_q) |-> $rose(bclk_q) && !zone_n_q)
		else $error("direction low off access start");
	sync_wait_a: assert property (tick && st_q == ST_ACT && cfg_q[`EMAS_B_USE_RDY] && !cfg_q[`EMAS_B_RDY_MODE]
		&& !rdy_s |=> st_q == ST_ACT && !rd_n_q | !wr_n_q)
		else $error("sync ready low did not hold the strobe");
	async_wait_a: assert property (tick && st_q == ST_ACT && cfg_q[`EMAS_B_USE_RDY] && cfg_q[`EMAS_B_RDY_MODE]
		&& !rdy_p_q[1] |=> st_q == ST_ACT)
		else $error("async ready low did not hold the strobe");
	tick_change_a: assert property ($changed(zone_n_q) || $changed(rd_n_q) || $changed(wr_n_q) |-> $past(tick))
		else $error("strobe changed off a timing clock tick");
	strobe_phase_a: assert property (!rd_n_q || !wr_n_q |-> st_q == ST_ACT && !zone_n_q)
		else $error("strobe active outside active phase");

	cov_write_c: cover property (st_q == ST_TRAIL && cur_wr_q ##1 st_q == ST_IDLE);
	cov_wait_c: cover property (st_q == ST_ACT && cfg_q[`EMAS_B_USE_RDY] [*4]);
	cov_align_c: cover property (st_q == ST_ALIGN ##1 st_q == ST_LEAD);
	cov_read_c: cover property (st_q == ST_ACT && !cur_wr_q ##1 st_q == ST_TRAIL);
endmodule

// *** logic/emas_sync2.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module emas_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_rst,
	// Asynchronous in, synchronous out
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule
